// ==== sbs_sram_ctrl.sv ====
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/1ns
// Behaviour
// - Interleaved burst XORs loaded low bits with count; wraps on fifth clock.
// - Sleep request high enters sleep two clock cycles later.
// - Sleep keeps burst counter, pipeline data and held state; only the output enable clears.
// - Sleep lasts exactly as long as the sleep request stays high.
// - Asleep, all command-port inputs are ignored; the APB registers still answer; data outputs float.
// - Sleep request is asynchronous, active high, outside the command set.
// - After sleep request falls, writes wait for the recovery time while the guard bit is set; reads and steps run.
// - Static pin selects flow-through or registered pipeline output.
// - Burst order pin low gives linear, high gives interleaved order.
// - Advance high steps the burst counter; low with select high loads external address.
module sbs_sram_ctrl (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [11:0]               paddr,
  input  wire logic [31:0]               pwdata,
  output logic [31:0]                    prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      sleep_request,
  input  wire logic                      burst_order_select,
  input  wire logic                      output_timing_select,
  input  wire logic                      cmd_select,
  input  wire logic                      cmd_write,
  input  wire logic                      burst_advance,
  input  wire logic [sbs_pkg::ADDR_W-1:0] cmd_addr,
  input  wire logic [sbs_pkg::DATA_W-1:0] wr_data,
  output logic [sbs_pkg::DATA_W-1:0]     rd_data,
  output logic                           rd_data_oe,
  output logic                           asleep
);
  sbs_pkg::sbs_sleep_e        state_q;
  sbs_pkg::sbs_sleep_e        state_d;
  logic [3:0]                 rec_q;
  logic [3:0]                 rec_d;
  logic                       slp_s1_q;
  logic                       slp_s2_q;
  logic                       bo_s1_q;
  logic                       bo_s2_q;
  logic                       tm_s1_q;
  logic                       tm_s2_q;
  logic                       accept;
  logic                       do_load;
  logic                       do_step;
  logic                       do_write;
  logic                       do_read;
  logic                       is_wr;
  logic                       wr_block;
  logic                       burst_q;
  logic                       burst_d;
  logic                       op_wr_q;
  logic                       op_wr_d;
  logic [sbs_pkg::ADDR_W-1:0] acc_addr;
  logic [sbs_pkg::DATA_W-1:0] rd_word;
  logic [sbs_pkg::DATA_W-1:0] mem [sbs_pkg::MEM_DEPTH];
  logic [sbs_pkg::DATA_W-1:0] stage_q;
  logic [sbs_pkg::DATA_W-1:0] stage_d;
  logic                       stage_v_q;
  logic                       stage_v_d;
  logic [sbs_pkg::DATA_W-1:0] out_q;
  logic [sbs_pkg::DATA_W-1:0] out_d;
  logic                       oe_q;
  logic                       oe_d;
  logic                       guard_q;
  logic                       guard_d;
  logic [15:0]                slpcnt_q;
  logic [15:0]                slpcnt_d;
  logic [31:0]                prdata_q;
  logic [31:0]                prdata_d;
  logic [31:0]                rd_mux;

  sbs_burst_if bif ();

  sbs_burst_gen u_gen (
    .pclk    (pclk),
    .presetn (presetn),
    .bif     (bif.gen)
  );

  // True when the offset names one of the registers
  function automatic logic reg_hit(input logic [11:0] a);
    reg_hit = (a == sbs_pkg::STATUS_OFS) || (a == sbs_pkg::CTRL_OFS) ||
              (a == sbs_pkg::SLPCNT_OFS);
  endfunction : reg_hit

  // Two-stage synchronisers for the asynchronous and strap pins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      slp_s1_q <= 1'b0;
      slp_s2_q <= 1'b0;
      bo_s1_q  <= 1'b0;
      bo_s2_q  <= 1'b0;
      tm_s1_q  <= 1'b0;
      tm_s2_q  <= 1'b0;
    end
    else
    begin
      slp_s1_q <= sleep_request;
      slp_s2_q <= slp_s1_q;
      bo_s1_q  <= burst_order_select;
      bo_s2_q  <= bo_s1_q;
      tm_s1_q  <= output_timing_select;
      tm_s2_q  <= tm_s1_q;
    end
  end

  // Sleep controller: entry, stay, and timed recovery
  always_comb
  begin
    state_d = state_q;
    rec_d   = rec_q;
    unique case (state_q)
      sbs_pkg::SBS_ACTIVE:
        if (slp_s2_q)
          state_d = sbs_pkg::SBS_ASLEEP;
      sbs_pkg::SBS_ASLEEP:
        if (!slp_s2_q)
        begin
          state_d = sbs_pkg::SBS_RECOVER;
          rec_d   = sbs_pkg::SLEEP_REC_CNT;
        end
      sbs_pkg::SBS_RECOVER:
        if (slp_s2_q)
          state_d = sbs_pkg::SBS_ASLEEP;
        else if (rec_q <= 4'h1)
          state_d = sbs_pkg::SBS_ACTIVE;
        else
          rec_d = rec_q - 4'h1;
      default:
        state_d = sbs_pkg::SBS_ACTIVE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= sbs_pkg::SBS_ACTIVE;
      rec_q   <= 4'h0;
    end
    else
    begin
      state_q <= state_d;
      rec_q   <= rec_d;
    end
  end

  // Command decode; nothing is taken while asleep or entering sleep
  always_comb
  begin
    accept   = (state_q != sbs_pkg::SBS_ASLEEP) &&
               (state_d != sbs_pkg::SBS_ASLEEP);
    wr_block = (state_q == sbs_pkg::SBS_RECOVER) && guard_q;
    do_step  = accept && burst_advance && burst_q;
    do_load  = accept && !burst_advance && cmd_select;
    is_wr    = do_load ? cmd_write : op_wr_q;
    do_write = (do_load || do_step) && is_wr && !wr_block;
    do_read  = (do_load || do_step) && !is_wr;
    acc_addr = do_load ? cmd_addr : bif.nxt_addr;
    rd_word  = mem[acc_addr];
    op_wr_d  = do_load ? cmd_write : op_wr_q;
    burst_d  = burst_q;
    if (accept)
      burst_d = burst_advance ? burst_q : cmd_select;
  end

  // Burst generator control
  assign bif.load       = do_load;
  assign bif.step       = do_step;
  assign bif.start_addr = cmd_addr;
  assign bif.interleave = bo_s2_q;

  // Array write port
  always_ff @(posedge pclk)
  begin
    if (do_write)
      mem[acc_addr] <= wr_data;
  end

  // Output path: flow-through or one extra pipeline register
  always_comb
  begin
    stage_d   = stage_q;
    stage_v_d = stage_v_q;
    out_d     = out_q;
    oe_d      = 1'b0;
    if (accept)
    begin
      stage_d   = rd_word;
      stage_v_d = do_read;
      out_d     = tm_s2_q ? rd_word : stage_q;
      oe_d      = tm_s2_q ? do_read : stage_v_q;
    end
  end

  // Held state other than oe_q survives sleep untouched; oe_q clears
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stage_q   <= '0;
      stage_v_q <= 1'b0;
      out_q     <= '0;
      oe_q      <= 1'b0;
      burst_q   <= 1'b0;
      op_wr_q   <= 1'b0;
    end
    else
    begin
      stage_q   <= stage_d;
      stage_v_q <= stage_v_d;
      out_q     <= out_d;
      oe_q      <= oe_d;
      burst_q   <= burst_d;
      op_wr_q   <= op_wr_d;
    end
  end

  // Register file: status, write guard and sleep entry count
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    rd_mux[sbs_pkg::ST_ASLEEP_BIT]  = (state_q == sbs_pkg::SBS_ASLEEP);
    rd_mux[sbs_pkg::ST_RECOVER_BIT] = (state_q == sbs_pkg::SBS_RECOVER);
    rd_mux[sbs_pkg::ST_COUNT_LSB +: 2] = bif.count;
    rd_mux[sbs_pkg::ST_ADDR_LSB +: sbs_pkg::ADDR_W] = bif.addr;
    rd_mux[sbs_pkg::ST_ILV_BIT] = bo_s2_q;
    rd_mux[sbs_pkg::ST_FLOW_BIT] = tm_s2_q;
    if (paddr == sbs_pkg::CTRL_OFS)
      rd_mux = {31'h0, guard_q};
    else if (paddr == sbs_pkg::SLPCNT_OFS)
      rd_mux = {16'h0000, slpcnt_q};
    else if (!reg_hit(paddr))
      rd_mux = 32'h0000_0000;
    prdata_d = (psel && !penable) ? rd_mux : prdata_q;
    guard_d  = guard_q;
    if (psel && penable && pwrite && paddr == sbs_pkg::CTRL_OFS)
      guard_d = pwdata[sbs_pkg::CTRL_GUARD_BIT];
    slpcnt_d = slpcnt_q;
    if (state_q != sbs_pkg::SBS_ASLEEP &&
        state_d == sbs_pkg::SBS_ASLEEP)
      slpcnt_d = slpcnt_q + 16'h0001;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q <= 32'h0000_0000;
      guard_q  <= sbs_pkg::CTRL_GUARD_RESET;
      slpcnt_q <= 16'h0000;
    end
    else
    begin
      prdata_q <= prdata_d;
      guard_q  <= guard_d;
      slpcnt_q <= slpcnt_d;
    end
  end

  // Bus answers with no wait state
  assign prdata  = prdata_q;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !reg_hit(paddr);

  // Pin outputs
  assign rd_data    = out_q;
  assign rd_data_oe = oe_q;
  assign asleep     = (state_q == sbs_pkg::SBS_ASLEEP);

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_sleep_rise;
    $rose(slp_s1_q) ##1 slp_s2_q;
  endsequence

  sequence s_wake;
    (state_q == sbs_pkg::SBS_ASLEEP && !slp_s2_q) ##1 !slp_s2_q;
  endsequence

  property p_entry;
    s_sleep_rise |=> state_q == sbs_pkg::SBS_ASLEEP;
  endproperty
  a_entry: assert property (p_entry)
    else $error("sleep not entered two cycles after request");

  property p_stay;
    state_q == sbs_pkg::SBS_ASLEEP && slp_s2_q |=>
      state_q == sbs_pkg::SBS_ASLEEP;
  endproperty
  a_stay: assert property (p_stay)
    else $error("left sleep while request still high");

  property p_wake;
    s_wake |-> state_q == sbs_pkg::SBS_RECOVER ##1
               state_q == sbs_pkg::SBS_ACTIVE;
  endproperty
  a_wake: assert property (p_wake)
    else $error("recovery did not last the recovery time");

  property p_guard;
    state_q == sbs_pkg::SBS_RECOVER && guard_q |-> !do_write;
  endproperty
  a_guard: assert property (p_guard)
    else $error("write accepted during sleep recovery");

  property p_quiet;
    state_q == sbs_pkg::SBS_ASLEEP |->
      !rd_data_oe && !bif.load && !bif.step && !do_write;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("activity or driven output while asleep");

  property p_retain;
    state_q == sbs_pkg::SBS_ASLEEP ##1 state_q == sbs_pkg::SBS_ASLEEP
      |-> $stable(stage_q) && $stable(bif.addr) && $stable(out_q);
  endproperty
  a_retain: assert property (p_retain)
    else $error("internal state changed during sleep");

  property p_flow;
    accept && do_read && tm_s2_q |=>
      rd_data_oe && rd_data == $past(rd_word);
  endproperty
  a_flow: assert property (p_flow)
    else $error("flow-through read data not presented");

  property p_pipe;
    accept && stage_v_q && !tm_s2_q |=>
      rd_data_oe && rd_data == $past(stage_q);
  endproperty
  a_pipe: assert property (p_pipe)
    else $error("pipelined read data not presented");

  property p_load;
    do_load |=> bif.addr == $past(cmd_addr) && bif.count == 2'h0;
  endproperty
  a_load: assert property (p_load)
    else $error("external start address not loaded");
endmodule : sbs_sram_ctrl

// ==== sbs_pkg.sv ====
package sbs_pkg;
  // Memory geometry
  localparam int ADDR_W    = 6;
  localparam int DATA_W    = 18;
  localparam int MEM_DEPTH = 64;
  localparam int APB_AW    = 12;

  // Register byte offsets
  localparam logic [11:0] STATUS_OFS = 12'h000;
  localparam logic [11:0] CTRL_OFS   = 12'h004;
  localparam logic [11:0] SLPCNT_OFS = 12'h008;

  // Status field positions
  localparam int ST_ASLEEP_BIT  = 0;
  localparam int ST_RECOVER_BIT = 1;
  localparam int ST_COUNT_LSB   = 2;
  localparam int ST_ADDR_LSB    = 4;
  localparam int ST_ILV_BIT     = 10;
  localparam int ST_FLOW_BIT    = 11;

  // Control fields and reset values
  localparam int   CTRL_GUARD_BIT   = 0;
  localparam logic CTRL_GUARD_RESET = 1'b1;

  // Sleep recovery time and its cycle count at 50 MHz
  localparam int SLEEP_REC_NS  = 20;
  localparam int CLK_PERIOD_NS = 20;
  localparam int SLEEP_REC_RAW =
    (SLEEP_REC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLEEP_REC_CYC = (SLEEP_REC_RAW < 1) ? 1 : SLEEP_REC_RAW;
  localparam int REC_W         = 4;
  localparam logic [3:0] SLEEP_REC_CNT = 4'(SLEEP_REC_CYC);

  // Sleep controller states, Gray coded from active through asleep to recover
  typedef enum logic [1:0] {
    SBS_ACTIVE  = 2'b00,
    SBS_ASLEEP  = 2'b01,
    SBS_RECOVER = 2'b11
  } sbs_sleep_e;
endpackage : sbs_pkg

// ==== sbs_burst_if.sv ====
`timescale 1ns/1ns
interface sbs_burst_if;
  logic                      load;
  logic                      step;
  logic                      interleave;
  logic [sbs_pkg::ADDR_W-1:0] start_addr;
  logic [sbs_pkg::ADDR_W-1:0] addr;
  logic [sbs_pkg::ADDR_W-1:0] nxt_addr;
  logic [1:0]                count;

  modport gen (
    input  load,
    input  step,
    input  interleave,
    input  start_addr,
    output addr,
    output nxt_addr,
    output count
  );
  modport user (
    output load,
    output step,
    output interleave,
    output start_addr,
    input  addr,
    input  nxt_addr,
    input  count
  );
endinterface : sbs_burst_if

// ==== sbs_burst_gen.sv ====
`timescale 1ns/1ns
module sbs_burst_gen (
  input  wire logic pclk,
  input  wire logic presetn,
  sbs_burst_if.gen  bif
);
  logic [sbs_pkg::ADDR_W-1:0] base_q;
  logic [sbs_pkg::ADDR_W-1:0] base_d;
  logic [1:0]                 cnt_q;
  logic [1:0]                 cnt_d;

  // Low address bits for a burst position in either order
  function automatic logic [1:0] burst_low(
    input logic [1:0] s,
    input logic [1:0] c,
    input logic       ilv
  );
    burst_low = ilv ? (s ^ c) : 2'(s + c);
  endfunction : burst_low

  // Load takes a new start, step counts and wraps after four
  always_comb
  begin
    base_d = base_q;
    cnt_d  = cnt_q;
    if (bif.load)
    begin
      base_d = bif.start_addr;
      cnt_d  = 2'h0;
    end
    else if (bif.step)
      cnt_d = cnt_q + 2'h1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      base_q <= '0;
      cnt_q  <= 2'h0;
    end
    else
    begin
      base_q <= base_d;
      cnt_q  <= cnt_d;
    end
  end

  // Upper bits come straight from the loaded start
  assign bif.addr     = {base_q[sbs_pkg::ADDR_W-1:2],
                         burst_low(base_q[1:0], cnt_q, bif.interleave)};
  assign bif.nxt_addr = {base_q[sbs_pkg::ADDR_W-1:2],
                         burst_low(base_q[1:0], cnt_q + 2'h1,
                                   bif.interleave)};
  assign bif.count    = cnt_q;

  sequence s_load_four;
    bif.load ##1 (bif.step && !bif.load) [*4];
  endsequence

  property p_wrap;
    @(posedge pclk) disable iff (!presetn)
    s_load_four |=> bif.addr == $past(bif.addr, 4);
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("burst did not wrap to start on fifth clock");

  property p_upper;
    @(posedge pclk) disable iff (!presetn)
    bif.step && !bif.load |=> bif.addr[5:2] == $past(bif.addr[5:2]);
  endproperty
  a_upper: assert property (p_upper)
    else $error("burst step changed upper address bits");

  property p_order;
    @(posedge pclk) disable iff (!presetn)
    bif.step && !bif.load && cnt_q == 2'h0 |=>
      bif.addr[1:0] == ($past(bif.interleave)
                        ? ($past(bif.addr[1:0]) ^ 2'h1)
                        : 2'($past(bif.addr[1:0]) + 2'h1));
  endproperty
  a_order: assert property (p_order)
    else $error("second burst address wrong for selected order");
endmodule : sbs_burst_gen

// ==== sbs_mc_model.sv ====
`timescale 1ns/1ns
// Memory controller model on the command port and the sleep pin
module sbs_mc_model (
  input  wire logic                        pclk,
  output logic                             cmd_select,
  output logic                             cmd_write,
  output logic                             burst_advance,
  output logic [sbs_pkg::ADDR_W-1:0]       cmd_addr,
  output logic [sbs_pkg::DATA_W-1:0]       wr_data,
  output logic                             sleep_request
);
  // Idle bus, sleep pin held low in normal operation
  initial
  begin
    cmd_select    = 1'b0;
    cmd_write     = 1'b0;
    burst_advance = 1'b0;
    cmd_addr      = '0;
    wr_data       = '0;
    sleep_request = 1'b0;
  end

  // One command per edge; unused lines toggle so stale values never match
  // Callers use only reads or deselects while the block recovers
  task automatic issue(input logic sel, input logic wr, input logic cont,
                       input logic [sbs_pkg::ADDR_W-1:0] a,
                       input logic [sbs_pkg::DATA_W-1:0] d,
                       input logic slp);
    @(posedge pclk);
    cmd_select    <= sel;
    cmd_write     <= wr;
    burst_advance <= cont;
    cmd_addr      <= (sel && !cont) ? a : ~cmd_addr;
    wr_data       <= (sel && wr) ? d : ~wr_data;
    sleep_request <= slp;
  endtask : issue
endmodule : sbs_mc_model

// ==== testbench.sv ====
`timescale 1ns/1ns
`define CHK(nm, ex, gt) \
  begin \
    n_tests++; \
    if ((gt) !== (ex)) \
    begin \
      n_fail++; \
      $display("unexpected %s: expected %h seen %h", nm, ex, gt); \
    end \
  end
module testbench;
  logic        pclk, presetn, psel, penable, pwrite, ilv, tsel;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic        pready, pslverr, rerr;
  logic        cmd_select, cmd_write, burst_advance, sleep_request;
  logic        rd_data_oe, asleep;
  logic [5:0]  cmd_addr;
  logic [17:0] wr_data, rd_data;
  logic [17:0] q[$];
  int          tq[$];
  int          n_fail, n_tests, cyc;

  // Clock and read-data monitor
  always #10 pclk = ~pclk;
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (rd_data_oe === 1'b1)
    begin
      q.push_back(rd_data);
      tq.push_back(cyc);
    end
  end

  sbs_sram_ctrl sbs_sram_ctrl_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sleep_request(sleep_request),
    .burst_order_select(ilv), .output_timing_select(tsel),
    .cmd_select(cmd_select), .cmd_write(cmd_write),
    .burst_advance(burst_advance), .cmd_addr(cmd_addr),
    .wr_data(wr_data), .rd_data(rd_data), .rd_data_oe(rd_data_oe),
    .asleep(asleep));

  sbs_mc_model sbs_mc_model_inst (
    .pclk(pclk), .cmd_select(cmd_select), .cmd_write(cmd_write),
    .burst_advance(burst_advance), .cmd_addr(cmd_addr),
    .wr_data(wr_data), .sleep_request(sleep_request));

  // Counts and verdict
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run

  // Reset held three cycles, then time for the pin synchronisers
  task automatic do_reset;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
  endtask : do_reset

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd);
    int i;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    if (i == 20)
    begin
      n_fail++;
      complete_run;
    end
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Bounded wait for n read beats
  task automatic wait_q(input int n);
    for (int i = 0; i < 20 && q.size() < n; i++)
      @(posedge pclk);
    if (q.size() < n)
    begin
      n_fail++;
      complete_run;
    end
  endtask : wait_q

  // Mode bits, control reset value, refused offset
  task automatic t_regs;
    apb(1'b0, 12'h000, 32'h0);
    `CHK("status modes", {tsel, ilv}, rdat[11:10]);
    `CHK("status idle", 2'b00, rdat[1:0]);
    apb(1'b0, 12'h004, 32'h0);
    `CHK("ctrl reset", 32'h00000001, rdat);
    apb(1'b1, 12'h004, 32'h0);
    apb(1'b0, 12'h004, 32'h0);
    `CHK("ctrl write", 32'h00000000, rdat);
    apb(1'b1, 12'h004, 32'h1);
    apb(1'b0, 12'h00C, 32'h0);
    `CHK("unmapped err", 1'b1, rerr);
    `CHK("unmapped data", 32'h00000000, rdat);
  endtask : t_regs

  // Fill a line, then a five-beat read burst from offset 1 of the line
  task automatic t_burst(input logic ilv_v, input logic tsel_v);
    int          c0;
    logic [1:0]  lb;
    ilv  <= ilv_v;
    tsel <= tsel_v;
    do_reset;
    for (int a = 6'h24; a < 6'h28; a++)
      sbs_mc_model_inst.issue(1, 1, 0, 6'(a), 18'h2A000 | 18'(a), 0);
    sbs_mc_model_inst.issue(0, 0, 0, 0, 0, 0);
    q.delete();
    tq.delete();
    sbs_mc_model_inst.issue(1, 0, 0, 6'h25, 0, 0);
    c0 = cyc;
    repeat (4) sbs_mc_model_inst.issue(0, 0, 1, 0, 0, 0);
    sbs_mc_model_inst.issue(0, 0, 0, 0, 0, 0);
    wait_q(5);
    // Flow-through shows data one edge sooner than pipeline
    `CHK("read latency", tsel_v ? 2 : 3, tq[0] - c0);
    for (int n = 0; n < 5; n++)
    begin
      lb = ilv_v ? (2'b01 ^ 2'(n)) : (2'b01 + 2'(n));
      `CHK("burst data", 18'h2A000 | {12'h0, 4'h9, lb}, q[n]);
    end
  endtask : t_burst

  // Sleep in mid-burst, ignored write, wake and wrap to the start
  task automatic t_sleep;
    ilv  <= 1'b1;
    tsel <= 1'b1;
    do_reset;
    q.delete();
    sbs_mc_model_inst.issue(1, 0, 0, 6'h26, 0, 0);
    sbs_mc_model_inst.issue(0, 0, 1, 0, 0, 0);
    sbs_mc_model_inst.issue(0, 0, 1, 0, 0, 1);
    sbs_mc_model_inst.issue(0, 0, 1, 0, 0, 1);
    @(negedge pclk) `CHK("asleep k", 1'b0, asleep);
    sbs_mc_model_inst.issue(1, 1, 0, 6'h26, 18'h3FFFF, 1);
    @(negedge pclk) `CHK("asleep k1", 1'b0, asleep);
    @(negedge pclk) `CHK("asleep k2", 1'b1, asleep);
    repeat (5) @(negedge pclk) `CHK("asleep hold", 1'b1, asleep);
    sbs_mc_model_inst.issue(0, 0, 1, 0, 0, 0);
    @(negedge pclk) `CHK("asleep j", 1'b1, asleep);
    @(negedge pclk) `CHK("asleep j1", 1'b1, asleep);
    // Synchronised pin falls two edges late; held step runs in recovery
    @(negedge pclk) `CHK("asleep j2", 1'b1, asleep);
    @(negedge pclk) `CHK("asleep j3", 1'b0, asleep);
    sbs_mc_model_inst.issue(0, 0, 0, 0, 0, 0);
    wait_q(5);
    repeat (3) @(posedge pclk);
    `CHK("beats", 5, q.size());
    for (int n = 0; n < 5; n++)
      `CHK("wake data", 18'h2A024 | 18'(2'b10 ^ 2'(n)), q[n]);
    q.delete();
    sbs_mc_model_inst.issue(1, 0, 0, 6'h26, 0, 0);
    sbs_mc_model_inst.issue(0, 0, 0, 0, 0, 0);
    wait_q(1);
    `CHK("write ignored", 18'h2A026, q[0]);
    apb(1'b0, 12'h008, 32'h0);
    `CHK("sleep count", 32'h00000001, rdat);
    apb(1'b0, 12'h000, 32'h0);
    `CHK("status modes set", 2'b11, rdat[11:10]);
    `CHK("status addr", 6'h26, rdat[9:4]);
  endtask : t_sleep

  // Main sequence
  initial
  begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
    paddr = '0; pwdata = '0; ilv = 0; tsel = 0;
    n_fail = 0; n_tests = 0; cyc = 0;
    do_reset;
    t_regs;
    t_burst(0, 1);
    t_burst(1, 1);
    t_burst(0, 0);
    t_burst(1, 0);
    t_sleep;
    complete_run;
  end
endmodule : testbench
